// ---- gpims_top.sv ----
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// six-port interrupt-select and mask register block on classic wishbone
module gpims_top #(
  parameter int NUM_PORTS  = gpims_pkg::NUM_PORTS,
  parameter int PORT_WIDTH = gpims_pkg::PORT_WIDTH
) (
  input  wire logic                            clk_i,      // system clock, 10 MHz
  input  wire logic                            rst_i,      // synchronous reset, high
  input  wire logic                            cyc_i,      // wishbone cycle
  input  wire logic                            stb_i,      // wishbone strobe
  input  wire logic                            we_i,       // wishbone write enable
  input  wire logic [11:0]                     adr_i,      // wishbone byte address
  input  wire logic [3:0]                      sel_i,      // wishbone byte selects
  input  wire logic [31:0]                     dat_i,      // wishbone write data
  output logic      [31:0]                     dat_o,      // wishbone read data
  output logic                                 ack_o,      // wishbone acknowledge
  output logic                                 irq_o,      // level interrupt
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in_i,   // pin levels, all ports
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] irq_src_o,  // pin may raise interrupt
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] dev_fn_o,   // pin given to device function
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] gpio_fn_o   // pin used as plain gpio
);
  localparam int TW = NUM_PORTS * PORT_WIDTH;

  gpims_pkg::gpims_bus_state_type state_reg;
  gpims_pkg::gpims_bus_state_type state_next;
  logic [31:0]    dat_reg;
  logic [31:0]    dat_next;
  logic [31:0]    stat_reg;
  logic [31:0]    stat_next;
  logic [31:0]    imask_reg;
  logic [31:0]    imask_next;
  logic           irq_reg;
  logic           irq_next;
  logic [TW-1:0]  src_reg;
  logic [TW-1:0]  dev_reg;
  logic [TW-1:0]  gpio_reg;
  logic [TW-1:0]  pin_prev_reg;
  logic [TW-1:0]  select_all;
  logic [TW-1:0]  mask_all;
  logic [31:0]    wdata;
  logic           access;
  logic           wr_go;
  logic           rd_go;
  logic [3:0]     port_idx;
  logic [7:0]     reg_ofs;
  logic           port_ok;
  logic [NUM_PORTS-1:0] port_hit;
  logic [NUM_PORTS-1:0] port_event;

  // only the selected byte lanes reach the set/clear logic; an unselected lane acts as zero
  assign wdata    = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign access   = cyc_i && stb_i && (state_reg == gpims_pkg::GPIMS_BUS_IDLE);
  // writes land on the edge where the master sees ack, so a dropped cycle writes nothing
  assign wr_go    = cyc_i && stb_i && we_i && (state_reg == gpims_pkg::GPIMS_BUS_ACK);
  assign rd_go    = access && !we_i;
  assign port_idx = adr_i[11:8];
  assign reg_ofs  = adr_i[7:0];
  assign port_ok  = (32'(port_idx) < NUM_PORTS);

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic [PORT_WIDTH-1:0] pin_now;
      logic [PORT_WIDTH-1:0] pin_old;
      logic [PORT_WIDTH-1:0] live_src;
      assign port_hit[gp] = wr_go && (32'(port_idx) == gp);
      gpims_port_bits #(
        .WIDTH(PORT_WIDTH)
      ) u_bits (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .sel_set_i (port_hit[gp] && reg_ofs == gpims_pkg::OFS_SEL_SET),
        .sel_clr_i (port_hit[gp] && reg_ofs == gpims_pkg::OFS_SEL_CLR),
        .msk_wr_i  (port_hit[gp] && reg_ofs == gpims_pkg::OFS_MASK),
        .msk_set_i (port_hit[gp] && reg_ofs == gpims_pkg::OFS_MASK_SET),
        .msk_clr_i (port_hit[gp] && reg_ofs == gpims_pkg::OFS_MASK_CLR),
        .data_i    (wdata[PORT_WIDTH-1:0]),
        .select_o  (select_all[gp*PORT_WIDTH +: PORT_WIDTH]),
        .mask_o    (mask_all[gp*PORT_WIDTH +: PORT_WIDTH])
      );
      assign pin_now  = pin_in_i[gp*PORT_WIDTH +: PORT_WIDTH];
      assign pin_old  = pin_prev_reg[gp*PORT_WIDTH +: PORT_WIDTH];
      // taken from the stored bits, not the registered outputs, so a mask write blocks at once
      assign live_src = select_all[gp*PORT_WIDTH +: PORT_WIDTH]
                      & ~mask_all[gp*PORT_WIDTH +: PORT_WIDTH];
      // simple rising-edge trigger: a live source pin that was low last cycle and is high now
      assign port_event[gp] = |(live_src & pin_now & ~pin_old);
    end
  endgenerate

  // bus slave: one wait-free ack the cycle after the request, dropped the cycle after
  always_comb begin
    state_next = gpims_pkg::GPIMS_BUS_IDLE;
    dat_next   = dat_reg;
    imask_next = imask_reg;
    stat_next  = stat_reg;
    if (access) begin
      state_next = gpims_pkg::GPIMS_BUS_ACK;
      dat_next   = gpims_pkg::UNMAPPED_READ;
      if (rd_go && port_ok && reg_ofs == gpims_pkg::OFS_SELECT) begin
        dat_next = 32'(select_all[32'(port_idx)*PORT_WIDTH +: PORT_WIDTH]);
      end
      if (rd_go && port_ok && reg_ofs == gpims_pkg::OFS_MASK) begin
        dat_next = 32'(mask_all[32'(port_idx)*PORT_WIDTH +: PORT_WIDTH]);
      end
      // set/clear words are write-only and read as zero
      if (rd_go && port_idx == 4'hf && reg_ofs == gpims_pkg::OFS_IRQ_STAT) begin
        dat_next  = stat_reg;
        stat_next = '0;
      end
      if (rd_go && port_idx == 4'hf && reg_ofs == gpims_pkg::OFS_IRQ_MASK) begin
        dat_next = imask_reg;
      end
    end
    if (wr_go && port_idx == 4'hf && reg_ofs == gpims_pkg::OFS_IRQ_MASK) begin
      imask_next = wdata;
    end
    // a new event wins over the clearing read
    stat_next = stat_next | 32'(port_event);
    irq_next  = |(stat_next & imask_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= gpims_pkg::GPIMS_BUS_IDLE;
      dat_reg   <= gpims_pkg::UNMAPPED_READ;
      stat_reg  <= '0;
      imask_reg <= gpims_pkg::IRQ_MASK_RST;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      dat_reg   <= dat_next;
      stat_reg  <= stat_next;
      imask_reg <= imask_next;
      irq_reg   <= irq_next;
    end
  end

  // pin function decode, registered so the outputs come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_reg      <= '0;
      dev_reg      <= '0;
      gpio_reg     <= '1;
      // start from the live level so a pin already high gives no false edge
      pin_prev_reg <= pin_in_i;
    end else begin
      src_reg      <= select_all & ~mask_all;
      dev_reg      <= ~select_all & ~mask_all;
      gpio_reg     <= ~select_all & mask_all;
      pin_prev_reg <= pin_in_i;
    end
  end

  assign dat_o     = dat_reg;
  // only the ack state has bit 0 set, so the flop bit is the acknowledge
  assign ack_o     = state_reg[0];
  assign irq_o     = irq_reg;
  assign irq_src_o = src_reg;
  assign dev_fn_o  = dev_reg;
  assign gpio_fn_o = gpio_reg;

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");
  a_mask_blocks_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (select_all[0] && mask_all[0]) |=> !irq_src_o[0])
    else $error("masked interrupt pin still a source");
  a_gpio_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (!select_all[0] && mask_all[0]) |=> (gpio_fn_o[0] && !dev_fn_o[0]))
    else $error("gpio decode wrong");
  a_select_dedicates: assert property (@(posedge clk_i) disable iff (rst_i)
    select_all[1] |=> (!gpio_fn_o[1] && !dev_fn_o[1]))
    else $error("interrupt pin also given another use");
endmodule // gpims_top

// ---- gpims_pkg.sv ----
// constants for the per-port interrupt-select and mask set/clear block
// Operation
// - select-set write ones set select bits
// - select-clear write ones clear select bits
// - mask-set write ones set mask bits
// - mask-clear write ones clear mask bits
// - select pin: mask zero enables interrupt
// - non-select pin: mask zero means device function
// - six readable writable 32-bit mask registers
// - write-only set and clear select registers
// - select one dedicates pin to interrupt
// - reset: select zero, mask all ones
package gpims_pkg;
  localparam int          NUM_PORTS     = 6;
  localparam int          PORT_WIDTH    = 32;
  localparam logic [11:0] PORT_STRIDE   = 12'h100;
  localparam logic [7:0]  OFS_SELECT    = 8'h10;
  localparam logic [7:0]  OFS_SEL_SET   = 8'h14;
  localparam logic [7:0]  OFS_SEL_CLR   = 8'h18;
  localparam logic [7:0]  OFS_MASK      = 8'h20;
  localparam logic [7:0]  OFS_MASK_SET  = 8'h24;
  localparam logic [7:0]  OFS_MASK_CLR  = 8'h28;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'hf0;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'hf4;
  localparam logic [31:0] SELECT_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET    = 32'hffff_ffff;
  localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    GPIMS_BUS_IDLE = 2'b00,
    GPIMS_BUS_ACK  = 2'b01
  } gpims_bus_state_type;
endpackage

// ---- gpims_port_bits.sv ----
`timescale 1ns/1ps
// one port's select and mask storage with atomic set/clear updates
module gpims_port_bits #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,      // system clock
  input  wire logic             rst_i,      // synchronous reset, high
  input  wire logic             sel_set_i,  // select-set strobe
  input  wire logic             sel_clr_i,  // select-clear strobe
  input  wire logic             msk_wr_i,   // mask direct write strobe
  input  wire logic             msk_set_i,  // mask-set strobe
  input  wire logic             msk_clr_i,  // mask-clear strobe
  input  wire logic [WIDTH-1:0] data_i,     // written word
  output logic      [WIDTH-1:0] select_o,   // pin_irq_select bits
  output logic      [WIDTH-1:0] mask_o      // pin_mask bits
);
  logic [WIDTH-1:0] select_reg;
  logic [WIDTH-1:0] select_next;
  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] mask_next;

  always_comb begin
    select_next = select_reg;
    mask_next   = mask_reg;
    if (sel_set_i) begin
      select_next = select_reg | data_i;
    end
    if (sel_clr_i) begin
      select_next = select_reg & ~data_i;
    end
    if (msk_wr_i) begin
      mask_next = data_i;
    end
    if (msk_set_i) begin
      mask_next = mask_reg | data_i;
    end
    if (msk_clr_i) begin
      mask_next = mask_reg & ~data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_reg <= WIDTH'(gpims_pkg::SELECT_RESET);
      mask_reg   <= WIDTH'(gpims_pkg::MASK_RESET);
    end else begin
      select_reg <= select_next;
      mask_reg   <= mask_next;
    end
  end

  assign select_o = select_reg;
  assign mask_o   = mask_reg;

  a_set_sets_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_set_i |=> ((select_reg & $past(data_i)) == $past(data_i)))
    else $error("select set did not set written ones");
  a_clr_clears_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_clr_i |=> ((select_reg & $past(data_i)) == '0))
    else $error("select clear did not clear written ones");
  a_mset_keeps_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
    msk_set_i |=> (((mask_reg ^ $past(mask_reg)) & ~$past(data_i)) == '0)
      && ((mask_reg & $past(data_i)) == $past(data_i)))
    else $error("mask set touched wrong bits");
  a_mclr_keeps_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
    msk_clr_i |=> (((mask_reg ^ $past(mask_reg)) & ~$past(data_i)) == '0)
      && ((mask_reg & $past(data_i)) == '0))
    else $error("mask clear touched wrong bits");
  a_reset_values: assert property (@(posedge clk_i)
    $past(rst_i) |-> (select_reg == '0 && mask_reg == '1))
    else $error("reset values wrong");
endmodule // gpims_port_bits

// ---- gpims_top_tb.sv ----
// self-checking bench for the six-port select and mask set/clear block
`timescale 1ns/1ps
module gpims_top_tb;
  localparam int NP = gpims_pkg::NUM_PORTS;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0;
  logic              stb_i = 1'b0;
  logic              we_i  = 1'b0;
  logic [11:0]       adr_i = 12'h000;
  logic [3:0]        sel_i = 4'hf;
  logic [31:0]       dat_i = 32'h0000_0000;
  logic [31:0]       dat_o;
  logic [31:0]       rd;
  logic              ack_o;
  logic              irq_o;
  logic [NP*32-1:0]  pin_in_i = '0;
  logic [NP*32-1:0]  irq_src_o;
  logic [NP*32-1:0]  dev_fn_o;
  logic [NP*32-1:0]  gpio_fn_o;
  logic [31:0]       sel_m [NP];
  logic [31:0]       msk_m [NP];
  logic [31:0]       rnd = 32'h0001_36de;
  int                err_total = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  gpims_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .pin_in_i(pin_in_i), .irq_src_o(irq_src_o), .dev_fn_o(dev_fn_o), .gpio_fn_o(gpio_fn_o));

  always #50 clk_i = ~clk_i;

  // whole run needs under a thousand cycles; this ceiling only cuts a hang
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] ad(input int p, input logic [7:0] o);
    return {p[3:0], o};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ack is sampled at the edge itself, so the release lands after that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    // no cycle count assumed here; only the bench ceiling ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic pchk(input int p);
    rchk("select", ad(p, gpims_pkg::OFS_SELECT), sel_m[p]);
    rchk("mask", ad(p, gpims_pkg::OFS_MASK), msk_m[p]);
    chk("irq_src", irq_src_o[p*32+:32], sel_m[p] & ~msk_m[p]);
    chk("dev_fn", dev_fn_o[p*32+:32], ~sel_m[p] & ~msk_m[p]);
    chk("gpio_fn", gpio_fn_o[p*32+:32], ~sel_m[p] & msk_m[p]);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    int p;
    int op;
    for (int i = 0; i < NP; i++) begin
      sel_m[i] = 32'h0000_0000;
      msk_m[i] = 32'hffff_ffff;
    end
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < NP; i++) pchk(i);
    for (int i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      p = int'(rnd[7:0]) % NP;
      op = int'(rnd[15:8]) % 5;
      rnd = lfsr(rnd);
      case (op)
        0: begin
          wb(1'b1, ad(p, gpims_pkg::OFS_SEL_SET), rnd);
          sel_m[p] |= rnd;
        end
        1: begin
          wb(1'b1, ad(p, gpims_pkg::OFS_SEL_CLR), rnd);
          sel_m[p] &= ~rnd;
        end
        2: begin
          wb(1'b1, ad(p, gpims_pkg::OFS_MASK_SET), rnd);
          msk_m[p] |= rnd;
        end
        3: begin
          wb(1'b1, ad(p, gpims_pkg::OFS_MASK_CLR), rnd);
          msk_m[p] &= ~rnd;
        end
        default: begin
          wb(1'b1, ad(p, gpims_pkg::OFS_MASK), rnd);
          msk_m[p] = rnd;
        end
      endcase
      pchk(p);
    end
    // refused and write-only places
    wb(1'b1, ad(0, gpims_pkg::OFS_SELECT), ~sel_m[0]);
    pchk(0);
    rchk("sel_set", ad(1, gpims_pkg::OFS_SEL_SET), 32'h0000_0000);
    rchk("sel_clr", ad(1, gpims_pkg::OFS_SEL_CLR), 32'h0000_0000);
    rchk("msk_set", ad(5, gpims_pkg::OFS_MASK_SET), 32'h0000_0000);
    rchk("msk_clr", ad(5, gpims_pkg::OFS_MASK_CLR), 32'h0000_0000);
    wb(1'b1, 12'h620, 32'h1234_5678);
    rchk("unmapped", 12'h620, 32'h0000_0000);
    // enabled interrupt source raises, read clears
    wb(1'b1, ad(2, gpims_pkg::OFS_SEL_SET), 32'h0000_0020);
    sel_m[2] |= 32'h0000_0020;
    wb(1'b1, ad(2, gpims_pkg::OFS_MASK_CLR), 32'h0000_0020);
    msk_m[2] &= ~32'h0000_0020;
    pchk(2);
    wb(1'b1, 12'hff4, 32'h0000_0004);
    rchk("irq_mask", 12'hff4, 32'h0000_0004);
    pin_in_i[69] <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h1);
    rchk("irq_stat", 12'hff0, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h0);
    rchk("irq_stat", 12'hff0, 32'h0000_0000);
    // mask bit one blocks the pin
    pin_in_i[69] <= 1'b0;
    wb(1'b1, ad(2, gpims_pkg::OFS_MASK_SET), 32'h0000_0020);
    msk_m[2] |= 32'h0000_0020;
    pin_in_i[69] <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk("irq_stat", 12'hff0, 32'h0000_0000);
    // status sets but a masked-off status keeps the line low
    wb(1'b1, 12'hff4, 32'h0000_0000);
    pin_in_i[69] <= 1'b0;
    wb(1'b1, ad(2, gpims_pkg::OFS_MASK_CLR), 32'h0000_0020);
    msk_m[2] &= ~32'h0000_0020;
    pin_in_i[69] <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h0);
    rchk("irq_stat", 12'hff0, 32'h0000_0004);
    pchk(2);
    summarize();
  end
endmodule // gpims_top_tb
